// ---- shared/tba_pkg.sv ----
`default_nettype none
package tba_pkg;
    localparam int TBA_AW = 6;
    localparam int TBA_DEPTH = 64;
    localparam int TBA_TW = 64;
    localparam int TBA_NBP = 15;
    localparam int TBA_NBASE = 9;
    localparam int TBA_FW = 3;
    localparam int TBA_XW = (TBA_NBP - TBA_NBASE) * TBA_FW;
    localparam int TBA_NVP = 2;
    localparam int TBA_VPW = 1;
    localparam int TBA_IDXW = 4;
    localparam int TBA_MODE_W = 5;
    localparam logic [TBA_AW-1:0] TBA_PTR_ONE = 6'h01;
    localparam logic [TBA_AW-1:0] TBA_PTR_RST = 6'h00;
    localparam logic [31:0] TBA_WORD_RST = 32'h00000000;

    // drseg byte offsets
    localparam logic [15:0] OFS_IBP_EXT = 16'h1FF8;
    localparam logic [15:0] OFS_DBP_EXT = 16'h2FF8;
    localparam logic [15:0] OFS_CTL_B = 16'h3008;
    localparam logic [15:0] OFS_CTL_C = 16'h3010;
    localparam logic [15:0] OFS_CTL_D = 16'h3018;
    localparam logic [15:0] OFS_TW_LO = 16'h3100;
    localparam logic [15:0] OFS_TW_HI = 16'h3104;
    localparam logic [15:0] OFS_RDP = 16'h3108;
    localparam logic [15:0] OFS_WRP = 16'h3110;
    localparam logic [15:0] OFS_STP = 16'h3118;
    // coprocessor register 23 selects
    localparam logic [2:0] SEL_SW_MODE = 3'h2;
    localparam logic [2:0] SEL_IBP = 3'h4;
    localparam logic [2:0] SEL_DBP = 3'h5;

    // trigger control fields
    localparam int BPC_MORE = 31;
    localparam int BPC_PCT = 29;
    localparam int BPC_EN = 28;
    // buffer control, trace mode and coherent enable fields
    localparam int CTB_CLR = 2;
    localparam int CTB_RDO = 3;
    localparam int CTB_FULL = 4;
    localparam int CTB_POL = 5;
    localparam int MODE_C_LSB = 23;
    localparam int MODE_SW_LSB = 7;
    localparam int CTD_CM_EN = 0;

    localparam logic POL_TRACE_TO = 1'b0;
    localparam logic POL_TRACE_FROM = 1'b1;
    localparam logic [2:0] ACT_NONE = 3'h0;
    localparam logic [2:0] ACT_OFF = 3'h1;
    localparam logic [2:0] ACT_ON = 3'h2;
    localparam logic [2:0] ACT_CM_ON = 3'h3;
endpackage
`default_nettype wire

// ---- shared/tba_trig_if.sv ----
`default_nettype none
interface tba_trig_if;
    import tba_pkg::*;
    logic [TBA_NBP-1:0] i_req;
    logic [TBA_NBP-1:0] d_req;
    logic sel_valid;
    logic sel_data;
    logic [TBA_IDXW-1:0] sel_idx;
    modport arb (input i_req, input d_req, output sel_valid, output sel_data, output sel_idx);
    modport core (output i_req, output d_req, input sel_valid, input sel_data, input sel_idx);
endinterface
`default_nettype wire

// ---- core/tba_trig_arb.sv ----
`default_nettype none
module tba_trig_arb
    import tba_pkg::*;
(
    tba_trig_if.arb t
);
    logic any_i;
    logic [TBA_NBP-1:0] pick;
    logic [TBA_NBP-1:0] below;
    logic [TBA_NBP-1:0] hot;

    assign any_i = |t.i_req;
    // instruction side wins the whole cycle
    assign pick = any_i ? t.i_req : t.d_req;

    for (genvar g = 0; g < TBA_NBP; g++) begin : g_pri
        if (g == 0) begin : g_first
            assign below[g] = 1'b0;
        end else begin : g_rest
            assign below[g] = below[g-1] | pick[g-1];
        end
        assign hot[g] = pick[g] & ~below[g];
    end

    always_comb begin
        t.sel_idx = '0;
        for (int k = 0; k < TBA_NBP; k++) begin
            if (hot[k]) begin
                t.sel_idx = t.sel_idx | TBA_IDXW'(k);
            end
        end
    end

    // purely combinational: one winner in the cycle the hits arrive
    assign t.sel_valid = |pick;
    assign t.sel_data = ~any_i;
endmodule
`default_nettype wire

// ---- core/tba_pair_buf.sv ----
`default_nettype none
module tba_pair_buf
    import tba_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [TBA_TW-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [TBA_TW-1:0] out_data
);
    typedef struct packed {
        logic [1:0][TBA_TW-1:0] slot;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } tba_buf_t;

    tba_buf_t q;
    tba_buf_t d;
    logic push;
    logic pop;

    assign in_ready = q.cnt != 2'h2;
    assign out_valid = q.cnt != 2'h0;
    assign out_data = q.slot[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.slot[q.wp] = in_data;
            d.wp = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ---- core/tba_trace_core.sv ----
// Behaviour
// - pointer clear zeroes read, write, start pointers
// - readout begin copies start into read pointer
// - trace word reads return entry halves, low half read advances pointer
// - trace-from policy stops writes when buffer full
// - full flag set in buffer control, pollable
// - read and write pointers take software writes
// - trigger control: 3-bit action, nine breakpoints
// - extension registers hold last six breakpoint actions
// - triggers set or clear coherent trace enable
// - instruction trigger beats data trigger same cycle
// - lowest numbered breakpoint wins within one side
// - trace mode from control C or software register
// - side enable bit suppresses all its triggers
// - no breakpoints present: trigger registers absent
// - trigger registers per virtual processor unless shared
// - bit 31 flags extra breakpoints, read-only
// - bit 30 reads zero, ignores writes
// - bit 29 gives perf pulse when enabled
// - bit 28 passes or blocks the triggers of its own side
// - action fields of absent breakpoints read zero
// - read pointer wraps to first location
`default_nettype none
module tba_trace_core
    import tba_pkg::*;
#(
    parameter int N_IBP = 15,
    parameter int N_DBP = 15
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reg_cp0,
    input wire logic [2:0] reg_sel,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic instr_bp_present,
    input wire logic data_bp_present,
    input wire logic instr_bp_shared,
    input wire logic data_bp_shared,
    input wire logic [TBA_VPW-1:0] acc_vp,
    input wire logic [TBA_VPW-1:0] hit_vp,
    input wire logic [TBA_NBP-1:0] ibp_hit,
    input wire logic [TBA_NBP-1:0] dbp_hit,
    input wire logic sw_control,
    input wire logic tw_valid,
    output logic tw_ready,
    input wire logic [TBA_TW-1:0] tw_data,
    output logic trig_valid,
    output logic trig_from_data,
    output logic [TBA_IDXW-1:0] trig_index,
    output logic [2:0] trig_action,
    output logic [TBA_MODE_W-1:0] trig_mode,
    output logic pct_instr,
    output logic pct_data,
    output logic coherent_trace_enable,
    output logic buffer_full_flag
);
    function automatic logic [31:0] base_mask(input int n);
        logic [31:0] m;
        m = '0;
        m[BPC_PCT] = 1'b1;
        m[BPC_EN] = 1'b1;
        for (int i = 0; i < TBA_NBASE; i++) begin
            if (i < n) begin
                m[TBA_FW*i +: TBA_FW] = '1;
            end
        end
        return m;
    endfunction

    function automatic logic [TBA_XW-1:0] ext_mask(input int n);
        logic [TBA_XW-1:0] m;
        m = '0;
        for (int i = 0; i < TBA_NBP - TBA_NBASE; i++) begin
            if (i + TBA_NBASE < n) begin
                m[TBA_FW*i +: TBA_FW] = '1;
            end
        end
        return m;
    endfunction

    localparam logic [31:0] IMASK = base_mask(N_IBP);
    localparam logic [31:0] DMASK = base_mask(N_DBP);
    localparam logic [TBA_XW-1:0] IXMASK = ext_mask(N_IBP);
    localparam logic [TBA_XW-1:0] DXMASK = ext_mask(N_DBP);
    localparam logic I_MORE = N_IBP > TBA_NBASE;
    localparam logic D_MORE = N_DBP > TBA_NBASE;

    typedef struct packed {
        logic [TBA_NVP-1:0][31:0] instr_bp_action_field;
        logic [TBA_NVP-1:0][31:0] dbpc;
        logic [TBA_NVP-1:0][TBA_XW-1:0] instr_bp_action_field_x;
        logic [TBA_NVP-1:0][TBA_XW-1:0] dbpc_x;
        logic policy;
        logic full;
        logic [TBA_MODE_W-1:0] mode_c;
        logic [TBA_MODE_W-1:0] mode_sw;
        logic cm_en;
        logic [TBA_AW-1:0] rdp;
        logic [TBA_AW-1:0] wrp;
        logic [TBA_AW-1:0] stp;
        logic [31:0] rdata;
        logic trig_valid;
        logic trig_data;
        logic [TBA_IDXW-1:0] trig_idx;
        logic [2:0] trig_act;
        logic [TBA_MODE_W-1:0] trig_mode;
        logic pct_i;
        logic pct_d;
    } tba_core_t;

    tba_core_t q;
    tba_core_t d;

    logic [TBA_TW-1:0] tmem [TBA_DEPTH];

    tba_trig_if trig_bus ();

    logic [TBA_VPW-1:0] avi;
    logic [TBA_VPW-1:0] avd;
    logic [TBA_VPW-1:0] tvi;
    logic [TBA_VPW-1:0] tvd;
    logic [TBA_NBP-1:0][2:0] i_act;
    logic [TBA_NBP-1:0][2:0] d_act;
    logic [2:0] win_act;
    logic buf_valid;
    logic buf_ready;
    logic [TBA_TW-1:0] buf_data;
    logic mem_we;
    logic [TBA_AW-1:0] wrp_next;
    logic sw_clr;
    logic sw_rdo;
    logic sw_wrp;
    logic [31:0] ctl_b_view;

    // shared breakpoints collapse onto copy zero for access and triggering
    assign avi = instr_bp_shared ? '0 : acc_vp;
    assign avd = data_bp_shared ? '0 : acc_vp;
    assign tvi = instr_bp_shared ? '0 : hit_vp;
    assign tvd = data_bp_shared ? '0 : hit_vp;

    for (genvar g = 0; g < TBA_NBP; g++) begin : g_bp
        if (g < TBA_NBASE) begin : g_base
            assign i_act[g] = q.instr_bp_action_field[tvi][TBA_FW*g +: TBA_FW];
            assign d_act[g] = q.dbpc[tvd][TBA_FW*g +: TBA_FW];
        end else begin : g_ext
            assign i_act[g] = q.instr_bp_action_field_x[tvi][TBA_FW*(g-TBA_NBASE) +: TBA_FW];
            assign d_act[g] = q.dbpc_x[tvd][TBA_FW*(g-TBA_NBASE) +: TBA_FW];
        end
        // a breakpoint with no action configured never competes
        assign trig_bus.i_req[g] = ibp_hit[g] && q.instr_bp_action_field[tvi][BPC_EN] && (i_act[g] != ACT_NONE);
        assign trig_bus.d_req[g] = dbp_hit[g] && q.dbpc[tvd][BPC_EN] && (d_act[g] != ACT_NONE);
    end

    tba_trig_arb u_arb (
        .t(trig_bus.arb)
    );

    assign win_act = trig_bus.sel_data ? d_act[trig_bus.sel_idx] : i_act[trig_bus.sel_idx];

    tba_pair_buf u_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(tw_valid),
        .in_ready(tw_ready),
        .in_data(tw_data),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    assign sw_clr = reg_wr && !reg_cp0 && reg_addr == OFS_CTL_B && reg_wdata[CTB_CLR];
    assign sw_rdo = reg_wr && !reg_cp0 && reg_addr == OFS_CTL_B && reg_wdata[CTB_RDO];
    assign sw_wrp = reg_wr && !reg_cp0 && reg_addr == OFS_WRP;

    // stall rather than drop: a word held back here waits in the pair buffer
    assign buf_ready = !sw_clr && !sw_wrp && !(q.policy == POL_TRACE_FROM && q.full);
    assign mem_we = buf_valid && buf_ready;
    assign wrp_next = q.wrp + TBA_PTR_ONE;

    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            tmem[q.wrp] <= buf_data;
        end
    end

    always_comb begin
        ctl_b_view = TBA_WORD_RST;
        ctl_b_view[CTB_FULL] = q.full;
        ctl_b_view[CTB_POL] = q.policy;
    end

    always_comb begin
        d = q;

        d.trig_valid = trig_bus.sel_valid;
        d.trig_data = trig_bus.sel_data;
        d.trig_idx = trig_bus.sel_idx;
        d.trig_act = win_act;
        d.trig_mode = sw_control ? q.mode_sw : q.mode_c;
        d.pct_i = q.instr_bp_action_field[tvi][BPC_PCT] && q.instr_bp_action_field[tvi][BPC_EN] && (|ibp_hit);
        d.pct_d = q.dbpc[tvd][BPC_PCT] && q.dbpc[tvd][BPC_EN] && (|dbp_hit);

        if (mem_we) begin
            d.wrp = wrp_next;
            // trace-to keeps the newest window: the oldest entry slides forward
            if (q.full) begin
                d.stp = q.stp + TBA_PTR_ONE;
            end
            if (wrp_next == q.stp) begin
                d.full = 1'b1;
            end
        end

        if (reg_wr) begin
            if (reg_cp0) begin
                if (reg_sel == SEL_IBP && instr_bp_present) begin
                    d.instr_bp_action_field[avi] = reg_wdata & IMASK;
                end else if (reg_sel == SEL_DBP && data_bp_present) begin
                    d.dbpc[avd] = reg_wdata & DMASK;
                end else if (reg_sel == SEL_SW_MODE) begin
                    d.mode_sw = reg_wdata[MODE_SW_LSB +: TBA_MODE_W];
                end
            end else if (reg_addr == OFS_IBP_EXT && instr_bp_present && I_MORE) begin
                d.instr_bp_action_field_x[avi] = reg_wdata[TBA_XW-1:0] & IXMASK;
            end else if (reg_addr == OFS_DBP_EXT && data_bp_present && D_MORE) begin
                d.dbpc_x[avd] = reg_wdata[TBA_XW-1:0] & DXMASK;
            end else if (reg_addr == OFS_CTL_B) begin
                d.policy = reg_wdata[CTB_POL];
            end else if (reg_addr == OFS_CTL_C) begin
                d.mode_c = reg_wdata[MODE_C_LSB +: TBA_MODE_W];
            end else if (reg_addr == OFS_CTL_D) begin
                d.cm_en = reg_wdata[CTD_CM_EN];
            end else if (reg_addr == OFS_RDP) begin
                d.rdp = reg_wdata[TBA_AW-1:0];
            end else if (reg_addr == OFS_WRP) begin
                d.wrp = reg_wdata[TBA_AW-1:0];
            end
        end

        // a trigger landing with a software write of the enable still counts
        if (trig_bus.sel_valid && win_act == ACT_CM_ON) begin
            d.cm_en = 1'b1;
        end else if (trig_bus.sel_valid && win_act == ACT_OFF) begin
            d.cm_en = 1'b0;
        end

        if (reg_rd) begin
            d.rdata = TBA_WORD_RST;
            if (reg_cp0) begin
                if (reg_sel == SEL_IBP && instr_bp_present) begin
                    d.rdata = q.instr_bp_action_field[avi];
                    d.rdata[BPC_MORE] = I_MORE;
                end else if (reg_sel == SEL_DBP && data_bp_present) begin
                    d.rdata = q.dbpc[avd];
                    d.rdata[BPC_MORE] = D_MORE;
                end else if (reg_sel == SEL_SW_MODE) begin
                    d.rdata[MODE_SW_LSB +: TBA_MODE_W] = q.mode_sw;
                end
            end else if (reg_addr == OFS_IBP_EXT && instr_bp_present && I_MORE) begin
                d.rdata[TBA_XW-1:0] = q.instr_bp_action_field_x[avi];
            end else if (reg_addr == OFS_DBP_EXT && data_bp_present && D_MORE) begin
                d.rdata[TBA_XW-1:0] = q.dbpc_x[avd];
            end else if (reg_addr == OFS_CTL_B) begin
                d.rdata = ctl_b_view;
            end else if (reg_addr == OFS_CTL_C) begin
                d.rdata[MODE_C_LSB +: TBA_MODE_W] = q.mode_c;
            end else if (reg_addr == OFS_CTL_D) begin
                d.rdata[CTD_CM_EN] = q.cm_en;
            end else if (reg_addr == OFS_TW_HI) begin
                // upper half first; it leaves the pointer alone
                d.rdata = tmem[q.rdp][TBA_TW-1:32];
            end else if (reg_addr == OFS_TW_LO) begin
                d.rdata = tmem[q.rdp][31:0];
                d.rdp = q.rdp + TBA_PTR_ONE;
            end else if (reg_addr == OFS_RDP) begin
                d.rdata[TBA_AW-1:0] = q.rdp;
            end else if (reg_addr == OFS_WRP) begin
                d.rdata[TBA_AW-1:0] = q.wrp;
            end else if (reg_addr == OFS_STP) begin
                d.rdata[TBA_AW-1:0] = q.stp;
            end
        end

        if (sw_rdo) begin
            d.rdp = q.stp;
        end

        // clear last so it beats readout and any direct pointer write
        if (sw_clr) begin
            d.rdp = TBA_PTR_RST;
            d.wrp = TBA_PTR_RST;
            d.stp = TBA_PTR_RST;
            d.full = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign trig_valid = q.trig_valid;
    assign trig_from_data = q.trig_data;
    assign trig_index = q.trig_idx;
    assign trig_action = q.trig_act;
    assign trig_mode = q.trig_mode;
    assign pct_instr = q.pct_i;
    assign pct_data = q.pct_d;
    assign coherent_trace_enable = q.cm_en;
    assign buffer_full_flag = q.full;
endmodule
`default_nettype wire

// ---- verification/tba_trace_core_checker.sv ----
`default_nettype none
module tba_trace_core_checker
    import tba_pkg::*;
#(
    parameter int N_IBP = 15,
    parameter int N_DBP = 15
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reg_cp0,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [TBA_NBP-1:0] ibp_hit,
    input wire logic [TBA_NBP-1:0] dbp_hit,
    input wire logic trig_valid,
    input wire logic trig_from_data,
    input wire logic [TBA_IDXW-1:0] trig_index,
    input wire logic [2:0] trig_action,
    input wire logic pct_instr,
    input wire logic pct_data,
    input wire logic coherent_trace_enable,
    input wire logic buffer_full_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic clr_w;
    logic cte_w;
    assign clr_w = reg_wr && !reg_cp0 && reg_addr == OFS_CTL_B && reg_wdata[CTB_CLR];
    assign cte_w = reg_wr && !reg_cp0 && reg_addr == OFS_CTL_D;
    sequence cm_on_s;
        trig_valid && trig_action == ACT_CM_ON;
    endsequence
    sequence cm_off_s;
        trig_valid && trig_action == ACT_OFF;
    endsequence
    trig_src_i_a: assert property (trig_valid && !trig_from_data |->
        |($past(ibp_hit) & (15'h0001 << trig_index))) else $error("instruction trigger without hit");
    trig_src_d_a: assert property (trig_valid && trig_from_data |->
        |($past(dbp_hit) & (15'h0001 << trig_index))) else $error("data trigger without hit");
    trig_act_a: assert property (trig_valid |-> trig_action != ACT_NONE)
        else $error("trigger with empty action");
    pct_instr_a: assert property (pct_instr |-> |$past(ibp_hit))
        else $error("perf pulse without instruction hit");
    pct_data_a: assert property (pct_data |-> |$past(dbp_hit))
        else $error("perf pulse without data hit");
    cm_on_a: assert property (cm_on_s |-> coherent_trace_enable)
        else $error("coherent enable not set");
    cm_off_a: assert property (cm_off_s |-> !coherent_trace_enable)
        else $error("coherent enable not cleared");
    cte_rise_a: assert property ($rose(coherent_trace_enable) |-> cm_on_s or $past(cte_w))
        else $error("coherent enable rose without cause");
    full_clr_a: assert property (clr_w |=> !buffer_full_flag)
        else $error("full flag survived pointer clear");
    full_fall_a: assert property ($fell(buffer_full_flag) |-> $past(clr_w))
        else $error("full flag dropped without clear");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without read");
endmodule
bind tba_trace_core tba_trace_core_checker #(.N_IBP(N_IBP), .N_DBP(N_DBP)) u_chk (.*);
`default_nettype wire

// ---- verification/tba_bp_unit_model.sv ----
`default_nettype none
module tba_bp_unit_model
    import tba_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [TBA_NBP-1:0] fire_i,
    input wire logic [TBA_NBP-1:0] fire_d,
    input wire logic [7:0] limit,
    input wire logic slow,
    output logic [7:0] sent,
    output logic [TBA_NBP-1:0] ibp_hit,
    output logic [TBA_NBP-1:0] dbp_hit,
    output logic tw_valid,
    input wire logic tw_ready,
    output logic [TBA_TW-1:0] tw_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] n;
    logic gap_q;
    assign n = {8'h00, sent};
    // idle bus shows the inverse so a stale word never passes as fresh
    assign tw_data = tw_valid ? {16'hC3A5, n, ~n, 16'h5A3C} : ~{16'hC3A5, n, ~n, 16'h5A3C};
    always_ff @(posedge ref_clk) begin
        ibp_hit <= nrst ? fire_i : 15'h0000;
        dbp_hit <= nrst ? fire_d : 15'h0000;
        if (!nrst) begin
            tw_valid <= 1'b0;
            sent <= 8'h00;
            gap_q <= 1'b0;
        end else if (tw_valid && tw_ready) begin
            sent <= sent + 8'h01;
            tw_valid <= !slow && (sent + 8'h01 < limit);
            gap_q <= slow;
        end else if (!tw_valid) begin
            tw_valid <= !gap_q && sent < limit;
            gap_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_trace_buffer_and_bp_trigger.sv ----
`default_nettype none
module tb_trace_buffer_and_bp_trigger
    import tba_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic w;
        logic cp;
        logic [2:0] s;
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } tba_row_t;
    typedef struct packed {
        logic [14:0] i;
        logic [14:0] d;
        logic s;
        logic [16:0] e;
    } tba_hit_t;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_cp0 = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sw_control = 1'b0, slow = 1'b1;
    logic instr_bp_present = 1'b1, data_bp_present = 1'b1, instr_bp_shared = 1'b0, data_bp_shared = 1'b0;
    logic [TBA_VPW-1:0] acc_vp = 1'h0, hit_vp = 1'h0;
    logic [2:0] reg_sel = 3'h0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [TBA_NBP-1:0] fire_i = 15'h0000, fire_d = 15'h0000;
    logic [7:0] limit = 8'h00;
    logic [31:0] reg_rdata;
    logic [TBA_NBP-1:0] ibp_hit, dbp_hit;
    logic tw_valid, tw_ready, trig_valid, trig_from_data, pct_instr, pct_data;
    logic coherent_trace_enable, buffer_full_flag;
    logic [TBA_TW-1:0] tw_data;
    logic [TBA_IDXW-1:0] trig_index;
    logic [2:0] trig_action;
    logic [TBA_MODE_W-1:0] trig_mode;
    logic [7:0] sent;
    logic [63:0] w;
    int mismatches = 0;
    int checks_done = 0;
    logic [15:0] pa [3] = '{OFS_RDP, OFS_WRP, OFS_STP};
    tba_row_t rows [11] = '{
        '{1'h0, 1'h1, SEL_IBP, 16'h0000, 32'h00000000, 32'h80000000},
        '{1'h1, 1'h1, SEL_IBP, 16'h0000, 32'hFFFFFFFF, 32'hB7FFFFFF},
        '{1'h1, 1'h1, SEL_DBP, 16'h0000, 32'hFFFFFFFF, 32'hB7FFFFFF},
        '{1'h1, 1'h0, 3'h0, OFS_IBP_EXT, 32'hFFFFFFFF, 32'h0003FFFF},
        '{1'h1, 1'h0, 3'h0, OFS_DBP_EXT, 32'hFFFFFFFF, 32'h000001FF},
        '{1'h1, 1'h0, 3'h0, OFS_CTL_C, 32'h0A800000, 32'h0A800000},
        '{1'h1, 1'h1, SEL_SW_MODE, 16'h0000, 32'h00000500, 32'h00000500},
        '{1'h1, 1'h0, 3'h0, 16'h3200, 32'hFFFFFFFF, 32'h00000000},
        '{1'h1, 1'h0, 3'h0, OFS_STP, 32'h0000003F, 32'h00000000},
        '{1'h1, 1'h0, 3'h0, OFS_WRP, 32'h00000025, 32'h00000025},
        '{1'h1, 1'h0, 3'h0, OFS_RDP, 32'h0000001A, 32'h0000001A}};
    // expected: valid, from_data, index, action, mode, coherent enable, perf pulses
    tba_hit_t hits [5] = '{
        '{15'h0006, 15'h0001, 1'h0, 17'h10AAB},
        '{15'h0004, 15'h0000, 1'h0, 17'h113AE},
        '{15'h0000, 15'h0003, 1'h0, 17'h181A9},
        '{15'h0001, 15'h0000, 1'h0, 17'h00002},
        '{15'h0400, 15'h0000, 1'h1, 17'h15252}};

    tba_trace_core #(.N_DBP(12)) DUT (.*);
    tba_bp_unit_model u_bpu (.*);

    always #4 ref_clk = ~ref_clk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic cp, input logic [2:0] s, input logic [15:0] a, input logic wr,
                       input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        reg_cp0 = cp;
        reg_sel = s;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask

    task automatic hit(input tba_hit_t h);
        logic [16:0] got;
        @(posedge ref_clk);
        #1;
        fire_i = h.i;
        fire_d = h.d;
        sw_control = h.s;
        @(posedge ref_clk);
        #1;
        fire_i = 15'h0000;
        fire_d = 15'h0000;
        @(posedge ref_clk);
        #1;
        got = {(trig_valid === 1'b1) ? {trig_valid, trig_from_data, trig_index, trig_action, trig_mode} : 14'h0000,
               coherent_trace_enable, pct_instr, pct_data};
        chk(got, h.e);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // budget is roughly forty times the expected run
    initial begin
        #160000;
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        chk({tw_ready, trig_valid, pct_instr, pct_data, coherent_trace_enable, buffer_full_flag}, 6'h20);
        foreach (rows[k]) begin
            if (rows[k].w) acc(rows[k].cp, rows[k].s, rows[k].a, 1'b1, rows[k].d);
            acc(rows[k].cp, rows[k].s, rows[k].a, 1'b0, 32'h0);
            chk(reg_rdata, rows[k].e);
        end
        acc(1'b0, 3'h0, OFS_CTL_B, 1'b1, 32'h00000024);
        foreach (pa[k]) begin
            acc(1'b0, 3'h0, pa[k], 1'b0, 32'h0);
            chk(reg_rdata, 32'h0);
        end
        // slow source first, then back to back until the buffer refuses
        limit = 8'h42;
        repeat (40) @(posedge ref_clk);
        #1;
        slow = 1'b0;
        for (int k = 0; k < 400 && sent != 8'h42; k++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        #1;
        chk({sent, tw_ready, buffer_full_flag}, {8'h42, 1'b0, 1'b1});
        acc(1'b0, 3'h0, OFS_CTL_B, 1'b0, 32'h0);
        chk(reg_rdata, 32'h00000030);
        acc(1'b0, 3'h0, OFS_RDP, 1'b1, 32'h00000005);
        acc(1'b0, 3'h0, OFS_CTL_B, 1'b1, 32'h00000028);
        for (int n = 0; n < 64; n++) begin
            w = {16'hC3A5, 16'(n), ~16'(n), 16'h5A3C};
            acc(1'b0, 3'h0, OFS_TW_HI, 1'b0, 32'h0);
            chk(reg_rdata, w[63:32]);
            acc(1'b0, 3'h0, OFS_TW_LO, 1'b0, 32'h0);
            chk(reg_rdata, w[31:0]);
        end
        acc(1'b0, 3'h0, OFS_RDP, 1'b0, 32'h0);
        chk(reg_rdata, 32'h0);
        acc(1'b0, 3'h0, OFS_CTL_B, 1'b1, 32'h00000024);
        chk(buffer_full_flag, 1'b0);
        repeat (4) @(posedge ref_clk);
        acc(1'b0, 3'h0, OFS_WRP, 1'b0, 32'h0);
        chk(reg_rdata, 32'h00000002);
        acc(1'b1, SEL_IBP, 16'h0000, 1'b1, 32'h300000D0);
        acc(1'b1, SEL_DBP, 16'h0000, 1'b1, 32'h30000001);
        acc(1'b0, 3'h0, OFS_IBP_EXT, 1'b1, 32'h00000010);
        foreach (hits[k]) hit(hits[k]);
        acc(1'b1, SEL_IBP, 16'h0000, 1'b1, 32'h200000D0);
        hit(tba_hit_t'{15'h0002, 15'h0001, 1'h0, 17'h181A9});
        acc_vp = 1'h1;
        hit_vp = 1'h1;
        acc(1'b1, SEL_IBP, 16'h0000, 1'b1, 32'h10000400);
        hit(tba_hit_t'{15'h0008, 15'h0000, 1'h0, 17'h11AA8});
        hit_vp = 1'h0;
        hit(tba_hit_t'{15'h0008, 15'h0000, 1'h0, 17'h00000});
        instr_bp_shared = 1'b1;
        hit_vp = 1'h1;
        acc(1'b1, SEL_IBP, 16'h0000, 1'b1, 32'h300000D0);
        hit(tba_hit_t'{15'h0004, 15'h0000, 1'h0, 17'h113AE});
        instr_bp_present = 1'b0;
        acc(1'b1, SEL_IBP, 16'h0000, 1'b0, 32'h0);
        chk(reg_rdata, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
